// ---- dv/rfat_reg_props.sv ----
// checker for one register word, bit layout as set up by the bench
`timescale 1ns/1ps
module rfat_reg_props
    import rfat_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire rfat_sw_req_t       sw_req,
    input wire rfat_hw_req_t       hw_req,
    input wire logic [RFAT_DW-1:0] field_q,
    input wire logic [RFAT_DW-1:0] rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_rw; sw_req.wr_en |=> field_q[31:7] == $past(sw_req.wdata[31:7]); endproperty
    a_rw: assert property (p_rw) else $error("bad rw");
    property p_w1c; sw_req.wr_en && sw_req.wdata[0] && !hw_req.set[0] |=> !field_q[0]; endproperty
    a_w1c: assert property (p_w1c) else $error("bad w1c");
    property p_w1s; sw_req.wr_en && sw_req.wdata[1] && !hw_req.load_en |=> field_q[1]; endproperty
    a_w1s: assert property (p_w1s) else $error("bad w1s");
    property p_rc; sw_req.rd_en && !hw_req.set[2] |=> rdata[2] == $past(field_q[2]) && !field_q[2];
    endproperty
    a_rc: assert property (p_rc) else $error("bad rc");
    property p_rwc; sw_req.wr_en && !hw_req.set[3] |=> !field_q[3]; endproperty
    a_rwc: assert property (p_rwc) else $error("bad rwc");
    property p_wo; sw_req.rd_en |=> rdata[5:4] == 2'h0; endproperty
    a_wo: assert property (p_wo) else $error("bad wo");
    property p_ro; sw_req.wr_en && !hw_req.load_en |=> $stable(field_q[6]); endproperty
    a_ro: assert property (p_ro) else $error("bad ro");
    property p_rst; $fell(reset) |-> field_q == '0 && rdata == '0; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
endmodule // rfat_reg_props
bind rfat_reg rfat_reg_props i_rfat_reg_props(.ref_clk, .reset, .sw_req, .hw_req, .field_q, .rdata);

// ---- dv/tb.sv ----
// bench for one register word of the field library
`timescale 1ns/1ps
module tb;
    import rfat_pkg::*;
    typedef struct {logic [31:0] s, w, e;} rfat_row_t;
    logic         ref_clk = 0;
    logic         reset = 1;
    rfat_sw_req_t sw = '0;
    rfat_hw_req_t hw = '0;
    logic [31:0]  q;
    logic [31:0]  rd;
    int           fail_count = 0;
    int           check_count = 0;
    rfat_row_t    rows [3] = '{'{32'h19, 32'h1234_5602, 32'h1234_5613},
        '{32'h0, 32'hffff_ff91, 32'hffff_ff82}, '{32'h9, 32'h8, 32'h3}};
    always #10 ref_clk = ~ref_clk;
    rfat_reg #(.ACCESS('{0: RFAT_RW1C, 1: RFAT_RW1S, 2: RFAT_RC, 3: RFAT_RWC, 4: RFAT_W1C,
        5: RFAT_WO, 6: RFAT_RO, default: RFAT_RW})) i_rfat_reg(.ref_clk, .reset,
        .sw_req(sw), .hw_req(hw), .field_q(q), .rdata(rd));
    task cyc(input logic w, r, input logic [31:0] d, s);
        @(posedge ref_clk);
        sw <= '{w, r, d};
        hw <= '{s, 1'b0, 32'h0};
        @(posedge ref_clk);
        sw <= '0;
        hw <= '0;
        #1;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge ref_clk);
        fail_count++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 0;
        #1;
        chk("reset q", 0, q);
        chk("reset rd", 0, rd);
        $display("test reset done");
        foreach (rows[i]) begin
            cyc(0, 0, 0, rows[i].s);
            cyc(1, 0, rows[i].w, 0);
            chk("row q", rows[i].e, q & 32'hffff_ffdb);
        end
        $display("test rows done");
        cyc(0, 0, 0, 32'h4);
        cyc(0, 1, 0, 0);
        chk("rc rd", 32'h4, rd & 32'h34);
        chk("rc q", 0, q[2]);
        cyc(0, 1, 0, 0);
        chk("rc again", 0, rd[2]);
        chk("status", 1, rd[0]);
        cyc(1, 0, rd, 32'h1);
        chk("new event", 1, q[0]);
        cyc(1, 0, 32'h1, 0);
        chk("w1c clear", 0, q[0]);
        @(posedge ref_clk);
        hw <= '{32'h0, 1'b1, 32'h40};
        @(posedge ref_clk);
        hw <= '0;
        #1;
        chk("ro load", 1, q[6]);
        chk("w1s hw clear", 0, q[1]);
        cyc(1, 0, 32'h0, 0);
        chk("ro kept", 1, q[6]);
        chk("w1s kept", 0, q[1]);
        @(posedge ref_clk);
        reset <= 1;
        repeat (2) @(posedge ref_clk);
        reset <= 0;
        #1;
        chk("rerun q", 0, q);
        chk("rerun rd", 0, rd);
        $display("test awkward done");
        give_verdict;
    end
endmodule // tb

// ---- hw/rfat_bit.sv ----
// one bit of a register with a selectable access type
`timescale 1ns/1ps
module rfat_bit
    import rfat_pkg::*;
#(
    parameter rfat_access_t ACCESS    = RFAT_RW,
    parameter logic         RST_VAL   = 1'b0,
    parameter logic         RST_KNOWN = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic wr_en,
    input  wire logic rd_en,
    input  wire logic wbit,
    input  wire logic hw_set,
    input  wire logic hw_load_en,
    input  wire logic hw_load_val,
    output logic      q,
    output logic      rbit
);

    logic bit_ff;
    logic nxt_bit;

    always_comb begin
        nxt_bit = bit_ff;
        case (ACCESS)
            RFAT_RO: begin
                if (hw_load_en) begin
                    nxt_bit = hw_load_val;
                end
            end
            RFAT_RW, RFAT_WO: begin
                if (wr_en) begin
                    nxt_bit = wbit;
                end
            end
            RFAT_RWC: begin
                if (wr_en) begin
                    nxt_bit = 1'b0;
                end
                if (hw_set) begin
                    nxt_bit = 1'b1;
                end
            end
            RFAT_RW1C, RFAT_W1C: begin
                if (wr_en && wbit) begin
                    nxt_bit = 1'b0;
                end
                if (hw_set) begin
                    nxt_bit = 1'b1;
                end
            end
            RFAT_RW1S: begin
                if (wr_en && wbit) begin
                    nxt_bit = 1'b1;
                end
                if (hw_load_en && !hw_load_val) begin
                    nxt_bit = 1'b0;
                end
            end
            RFAT_RC: begin
                if (rd_en) begin
                    nxt_bit = 1'b0;
                end
                if (hw_set) begin
                    nxt_bit = 1'b1;
                end
            end
            default: begin
                nxt_bit = bit_ff;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset && RST_KNOWN) begin
            bit_ff <= RST_VAL;
        end else if (!reset) begin
            bit_ff <= nxt_bit;
        end
    end

    always_comb begin
        q = bit_ff;
        case (ACCESS)
            RFAT_W1C, RFAT_WO: rbit = 1'b0;
            default:           rbit = bit_ff;
        endcase
    end

endmodule // rfat_bit

// ---- hw/rfat_pkg.sv ----
// package: access types, request structs and reset values for the field library
package rfat_pkg;

    localparam int unsigned RFAT_DW = 32;

    typedef enum logic [2:0] {
        RFAT_RO,
        RFAT_RW,
        RFAT_RWC,
        RFAT_RW1C,
        RFAT_RW1S,
        RFAT_W1C,
        RFAT_WO,
        RFAT_RC
    } rfat_access_t;

    // software side of one register access
    typedef struct packed {
        logic              wr_en;
        logic              rd_en;
        logic [RFAT_DW-1:0] wdata;
    } rfat_sw_req_t;

    // hardware side: event set and load of status values
    typedef struct packed {
        logic [RFAT_DW-1:0] set;
        logic              load_en;
        logic [RFAT_DW-1:0] load_val;
    } rfat_hw_req_t;

    localparam logic [RFAT_DW-1:0] RFAT_RESET_VALUE = 32'h0000_0000;
    localparam logic [RFAT_DW-1:0] RFAT_RESET_KNOWN = 32'hffff_ffff;
    localparam logic [RFAT_DW-1:0] RFAT_RO_DATA     = 32'h0000_0000;
    localparam logic [RFAT_DW-1:0] RFAT_JUNK_DATA   = 32'h0000_0000;

endpackage

// ---- hw/rfat_reg.sv ----
// one register word built from per-bit access types
//
// What this block does
// - any write to a clear-on-any-write register clears all of it, and it stays readable.
// - a readable write-one-to-clear bit clears on a written 1 and keeps its value on a 0.
// - writing back a read status word clears only the bits seen set, newer events survive.
// - a write-one-to-set bit is readable and a written 0 leaves it as it is.
// - a write-only write-one-to-clear bit clears on 1, ignores 0, and reads return 0.
// - a write-only field takes writes only and reads return 0.
// - after reset each field holds its reset value of 0, 1 or undefined.
// - a read/write field reads back the last written value or its reset value.
// - a clear-on-read field returns its value and is then cleared by that read.
`timescale 1ns/1ps
module rfat_reg
    import rfat_pkg::*;
#(
    parameter rfat_access_t     ACCESS [RFAT_DW] = '{default: RFAT_RW},
    parameter logic [RFAT_DW-1:0] RST_VAL   = RFAT_RESET_VALUE,
    parameter logic [RFAT_DW-1:0] RST_KNOWN = RFAT_RESET_KNOWN
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire rfat_sw_req_t       sw_req,
    input  wire rfat_hw_req_t       hw_req,
    output logic [RFAT_DW-1:0]      field_q,
    output logic [RFAT_DW-1:0]      rdata
);

    logic [RFAT_DW-1:0] rbits;
    logic [RFAT_DW-1:0] rdata_ff;
    logic [RFAT_DW-1:0] nxt_rdata;

    genvar i;
    generate
        for (i = 0; i < RFAT_DW; i++) begin : g_bit
            rfat_bit #(
                .ACCESS    (ACCESS[i]),
                .RST_VAL   (RST_VAL[i]),
                .RST_KNOWN (RST_KNOWN[i])
            ) u_bit (
                .ref_clk     (ref_clk),
                .reset       (reset),
                .wr_en       (sw_req.wr_en),
                .rd_en       (sw_req.rd_en),
                .wbit        (sw_req.wdata[i]),
                .hw_set      (hw_req.set[i]),
                .hw_load_en  (hw_req.load_en),
                .hw_load_val (hw_req.load_val[i]),
                .q           (field_q[i]),
                .rbit        (rbits[i])
            );
        end
    endgenerate

    // read data captured at the read, before any clear-on-read takes effect
    always_comb begin
        nxt_rdata = rdata_ff;
        if (sw_req.rd_en) begin
            nxt_rdata = rbits;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= RFAT_RO_DATA;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;

endmodule // rfat_reg
